//--- logic/evps_cfg.svh
`ifndef EVPS_CFG_SVH
`define EVPS_CFG_SVH
// Notes on behaviour
// - One of three modes per card
// - Switch group: one fabric, STS-3c total
// - Add/drop ring node doubles group bandwidth
// - Single-card switch allows up to STS-12c
// - Port-mapped: each port to own circuit
// - Frames above 1522 bytes are not carried
// - Port-mapped bypasses all Layer 2 functions
// - Port-mapped never parses, adds or strips tags
// - Advertise symmetric pause in auto-negotiation
// - Pause only when both ends auto-negotiate
// - Halt on received pause; send when congested
// - Pause throttles station to circuit rate
// - Up to 509 VLANs held
// - Forwarding confined to VLAN member ports
// - Untagged ingress gets port VLAN tag
// - Strip ports remove internal tag on egress; code keeps it for frames that entered on a keep-tag port
// - Keep-tag ports reuse and keep tag
// - Eight priorities map to two queues
// - Weighted 70/30 service, low never starved
// - Drop packets when queues overflow
// - Priorities 0-3 low, 4-7 high
// - Port-mapped: single FIFO, no priority

// Register byte addresses
`define A_CTRL 8'h00
`define A_PVID_LO 8'h04
`define A_PVID_HI 8'h08
`define A_CIRC 8'h0C
`define A_VIDX 8'h10
`define A_VDATA 8'h14
`define A_STATUS 8'h18
`define A_DROPS 8'h1C
// Control fields
`define F_MODE 1:0
`define F_ADDDROP 2
`define F_AN 7:4
`define F_KEEP 11:8
`define CTRL_RST 32'h0000_00F0
`define PVID_RST 32'h0001_0001
`define MODE_BAD 2'h3
// VLAN table entry: [20] valid, [19:12] members, [11:0] vid
`define E_VALID 20
`define E_MEM 19:12
`define E_VID 11:0
`define VLAN_MAX 10'h1FD
// Circuit capacity in STS-1 units per mode
`define CAP_MULTI 5'h03
`define CAP_SINGLE 5'h0C
`define CAP_PM 5'h0C
`define FRAME_MAX 11'h5F2
// Timing
`define PCLK_NS 20
`define PCLK_MHZ 50
`define QUANTUM_NS 5120
`define QUANTUM_CYC (`QUANTUM_NS / `PCLK_NS)
`define STS1_KBPS 51840
`define STS1_GAIN ((`STS1_KBPS) / (8 * `PCLK_MHZ))
`define BYTE_COST 10'h3E8
`define BKT_MAX 25'sh1E8480
// Scheduler
`define Q_DEPTH 4
`define W_TOTAL 4'hA
`define W_HIGH 4'h7
`define DESC_W 40
`endif

//--- logic/evps_pkg.sv
package evps_pkg;
   typedef enum logic [1:0] {MODE_MULTI, MODE_SINGLE, MODE_PORTMAP} mode_t;
   typedef enum logic [1:0] {TAG_NONE, TAG_KEEP, TAG_INSERT} tag_op_t;
endpackage

//--- logic/evps_wsched.sv
`timescale 1ns/1ns
`default_nettype none
`include "evps_cfg.svh"
module evps_wsched (
   input wire logic clk, // Bus clock
   input wire logic rst_n, // Async reset, active low
   input wire logic single, // One FIFO, no priority
   input wire logic enq_valid, // Descriptor offered
   input wire logic enq_hi, // Wants high queue
   input wire logic [`DESC_W-1:0] enq_data, // Descriptor
   input wire logic deq_ready, // Drain side can take
   output logic deq_valid, // Descriptor available
   output logic [`DESC_W-1:0] deq_data, // Head descriptor
   output logic congest, // A queue is nearly full
   output logic drop // Offered descriptor was lost
);
   logic [`DESC_W-1:0] mem_ff [2][`Q_DEPTH];
   logic [1:0] wp_ff [2];
   logic [1:0] rp_ff [2];
   logic [2:0] cnt_ff [2];
   logic [3:0] slot_ff;
   logic drop_ff, congest_ff, sel, tgt, full_t;

   // Queue choice; port-mapped frames all share the low queue
   assign tgt = enq_hi & ~single;
   assign full_t = cnt_ff[tgt] == 3'(`Q_DEPTH);
   // High wins during the first seven slots of ten, low in the rest
   assign sel = cnt_ff[1] != 3'h0 && (cnt_ff[0] == 3'h0 || slot_ff < `W_HIGH);
   assign deq_valid = cnt_ff[0] != 3'h0 || cnt_ff[1] != 3'h0;
   assign deq_data = mem_ff[sel][rp_ff[sel]];
   assign congest = congest_ff;
   assign drop = drop_ff;

   for (genvar q = 0; q < 2; q++) begin : g_q
      logic push, pop;
      assign push = enq_valid && tgt == 1'(q) && !full_t;
      assign pop = deq_valid && deq_ready && sel == 1'(q);
      // Pointer and occupancy update per queue
      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            wp_ff[q] <= 2'h0;
            rp_ff[q] <= 2'h0;
            cnt_ff[q] <= 3'h0;
         end else begin
            if (push) begin
               wp_ff[q] <= wp_ff[q] + 2'h1;
            end
            if (pop) begin
               rp_ff[q] <= rp_ff[q] + 2'h1;
            end
            cnt_ff[q] <= cnt_ff[q] + 3'(push) - 3'(pop);
         end
      end
      // Storage write
      always_ff @(posedge clk) begin
         if (push) begin
            mem_ff[q][wp_ff[q]] <= enq_data;
         end
      end
   end

   // Weight slot, drop and congestion flags
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         slot_ff <= 4'h0;
         drop_ff <= 1'b0;
         congest_ff <= 1'b0;
      end else begin
         if (deq_valid && deq_ready) begin
            slot_ff <= (slot_ff == `W_TOTAL - 4'h1) ? 4'h0 : slot_ff + 4'h1;
         end
         drop_ff <= enq_valid && full_t;
         congest_ff <= cnt_ff[0] >= 3'(`Q_DEPTH - 1) || cnt_ff[1] >= 3'(`Q_DEPTH - 1);
      end
   end

   // Count of consecutive high services while low waits
   logic [3:0] hi_run_ff;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         hi_run_ff <= 4'h0;
      end else if (deq_valid && deq_ready) begin
         hi_run_ff <= (sel && cnt_ff[0] != 3'h0) ? hi_run_ff + 4'h1 : 4'h0;
      end
   end

   a_low_served: assert property (@(posedge clk) disable iff (!rst_n) hi_run_ff <= 4'h7)
      else $error("low queue starved");
   a_drop_full: assert property (@(posedge clk) disable iff (!rst_n)
      enq_valid && full_t |=> drop)
      else $error("overflow not dropped");
   c_drop: cover property (@(posedge clk) disable iff (!rst_n) drop);
endmodule
`default_nettype wire

//--- logic/evps_switch.sv
// Design decisions made here: the APB interface to the registers and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "evps_cfg.svh"
module evps_switch (
   input wire logic pclk, // 50 MHz clock
   input wire logic presetn, // Async reset, active low
   input wire logic psel, // APB select
   input wire logic penable, // APB access phase
   input wire logic pwrite, // APB write
   input wire logic [7:0] paddr, // APB byte address
   input wire logic [31:0] pwdata, // APB write data
   output logic [31:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr, // APB error
   input wire logic in_valid, // Frame descriptor from a station
   input wire logic [1:0] in_port, // Ingress station port
   input wire logic in_tagged, // Frame carries a tag
   input wire logic [11:0] in_vid, // Tag VLAN
   input wire logic [2:0] in_pcp, // Tag priority
   input wire logic [10:0] in_len, // Frame bytes
   input wire logic [3:0] partner_an, // Station auto-negotiates
   input wire logic rx_pause_valid, // Pause frame received
   input wire logic [1:0] rx_pause_port, // Port it came in on
   input wire logic [15:0] rx_pause_quanta, // Pause time
   input wire logic out_ready, // Egress accepts
   output logic out_valid, // Egress descriptor valid
   output logic [7:0] out_dest, // [3:0] stations, [7:4] circuits
   output logic [3:0] out_untag, // Stations that strip the tag
   output logic [11:0] out_vid, // VLAN
   output logic [2:0] out_pcp, // Priority
   output var evps_pkg::tag_op_t out_tag_op, // Tag handling
   output logic [10:0] out_len, // Frame bytes
   output logic [3:0] adv_sym_pause, // Advertise symmetric pause
   output logic [3:0] tx_hold, // Transmit to station halted
   output logic [3:0] tx_pause // Send pause frame, pulse
);
   logic [31:0] ctrl_ff, pvid_lo_ff, pvid_hi_ff, circ_ff, prdata_ff, nxt_prdata;
   logic [8:0] vidx_ff;
   logic [9:0] vcnt_ff;
   logic [15:0] drops_ff;
   logic [20:0] vtab_ff [512];
   logic pready_ff, pslverr_ff, nxt_err, wr;
   logic [4:0] cap;
   logic [5:0] circ_sum;
   evps_pkg::mode_t mode;
   logic pm;
   logic [3:0] keep, fc, hold_w, pause_w, over_w;
   logic congest;

   assign mode = evps_pkg::mode_t'(ctrl_ff[`F_MODE]);
   assign pm = mode == evps_pkg::MODE_PORTMAP;
   assign keep = ctrl_ff[`F_KEEP];
   assign fc = ctrl_ff[`F_AN] & partner_an;
   assign wr = psel && penable && pready_ff && pwrite && !pslverr_ff;

   // Circuit bandwidth ceiling of the current mode
   always_comb begin
      unique case (mode)
         evps_pkg::MODE_MULTI: cap = ctrl_ff[`F_ADDDROP] ? `CAP_MULTI << 1 : `CAP_MULTI;
         evps_pkg::MODE_SINGLE: cap = `CAP_SINGLE;
         default: cap = `CAP_PM;
      endcase
   end
   // Sum is six bits wide so four full nibbles cannot wrap under the ceiling
   assign circ_sum = 6'(pwdata[3:0]) + 6'(pwdata[7:4]) + 6'(pwdata[11:8]) + 6'(pwdata[15:12]);

   // Read mux and refusal check, evaluated in the setup cycle
   always_comb begin
      nxt_prdata = 32'h0;
      nxt_err = 1'b0;
      unique case (paddr)
         `A_CTRL: begin
            nxt_prdata = ctrl_ff;
            nxt_err = pwrite && pwdata[`F_MODE] == `MODE_BAD;
         end
         `A_PVID_LO: nxt_prdata = pvid_lo_ff;
         `A_PVID_HI: nxt_prdata = pvid_hi_ff;
         `A_CIRC: begin
            nxt_prdata = circ_ff;
            nxt_err = pwrite && circ_sum > 6'(cap);
         end
         `A_VIDX: nxt_prdata = {23'h0, vidx_ff};
         `A_VDATA: begin
            nxt_prdata = {11'h0, vtab_ff[vidx_ff]};
            nxt_err = pwrite && pwdata[`E_VALID] && !vtab_ff[vidx_ff][`E_VALID]
               && vcnt_ff >= `VLAN_MAX;
         end
         `A_STATUS: nxt_prdata = {10'h0, vcnt_ff, over_w, congest, 3'h0, hold_w};
         `A_DROPS: nxt_prdata = {16'h0, drops_ff};
         default: nxt_err = 1'b1;
      endcase
   end

   // APB answer: ready in the first access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff <= 32'h0;
      end else begin
         pready_ff <= psel && !penable;
         pslverr_ff <= psel && !penable && nxt_err;
         if (psel && !penable) begin
            prdata_ff <= nxt_prdata;
         end
      end
   end
   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;

   // Configuration registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_ff <= `CTRL_RST;
         pvid_lo_ff <= `PVID_RST;
         pvid_hi_ff <= `PVID_RST;
         circ_ff <= 32'h0;
         vidx_ff <= 9'h0;
      end else if (wr) begin
         unique case (paddr)
            `A_CTRL: ctrl_ff <= {20'h0, pwdata[11:0]};
            `A_PVID_LO: pvid_lo_ff <= pwdata & 32'h0FFF_0FFF;
            `A_PVID_HI: pvid_hi_ff <= pwdata & 32'h0FFF_0FFF;
            `A_CIRC: circ_ff <= {16'h0, pwdata[15:0]};
            `A_VIDX: vidx_ff <= pwdata[8:0];
            default: ;
         endcase
      end
   end

   // VLAN table and occupancy count
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < 512; i++) begin
            vtab_ff[i] <= 21'h0;
         end
         vcnt_ff <= 10'h0;
      end else if (wr && paddr == `A_VDATA) begin
         vtab_ff[vidx_ff] <= pwdata[20:0];
         vcnt_ff <= vcnt_ff + 10'(pwdata[`E_VALID]) - 10'(vtab_ff[vidx_ff][`E_VALID]);
      end
   end

   // Ingress classification
   logic [11:0] pvid, vid_use, c_vid;
   logic [20:0] ent;
   logic [7:0] members, c_dest;
   logic [3:0] c_untag;
   logic c_hi, enq_ok, s_drop;
   evps_pkg::tag_op_t c_op;

   always_comb begin
      unique case (in_port)
         2'h0: pvid = pvid_lo_ff[11:0];
         2'h1: pvid = pvid_lo_ff[27:16];
         2'h2: pvid = pvid_hi_ff[11:0];
         default: pvid = pvid_hi_ff[27:16];
      endcase
   end
   assign vid_use = in_tagged ? in_vid : pvid;
   assign ent = vtab_ff[vid_use[8:0]];
   assign members = (ent[`E_VALID] && ent[`E_VID] == vid_use) ?
      ent[`E_MEM] & ~(8'h01 << in_port) : 8'h00;

   always_comb begin
      c_dest = 8'h00;
      c_vid = in_vid;
      c_op = evps_pkg::TAG_NONE;
      c_hi = 1'b0;
      c_untag = 4'h0;
      if (pm) begin
         c_dest = 8'h10 << in_port;
      end else begin
         c_dest = members;
         c_vid = vid_use;
         c_op = in_tagged ? evps_pkg::TAG_KEEP : evps_pkg::TAG_INSERT;
         c_hi = in_tagged && in_pcp[2];
         c_untag = keep[in_port] ? 4'h0 : members[3:0] & ~keep;
      end
   end
   assign enq_ok = in_valid && in_len <= `FRAME_MAX && c_dest != 8'h00;

   // Two weighted queues, or one FIFO when port-mapped
   logic deq_ready, deq_valid;
   logic [`DESC_W-1:0] deq_data;
   evps_wsched u_sched (
      .clk(pclk),
      .rst_n(presetn),
      .single(pm),
      .enq_valid(enq_ok),
      .enq_hi(c_hi),
      .enq_data({c_dest, c_untag, c_vid, in_pcp, c_op, in_len}),
      .deq_ready(deq_ready),
      .deq_valid(deq_valid),
      .deq_data(deq_data),
      .congest(congest),
      .drop(s_drop)
   );

   // Egress register stage
   logic out_valid_ff;
   logic [`DESC_W-1:0] out_ff;
   assign deq_ready = !out_valid_ff || out_ready;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_valid_ff <= 1'b0;
         out_ff <= '0;
      end else if (deq_ready) begin
         out_valid_ff <= deq_valid;
         if (deq_valid) begin
            out_ff <= deq_data;
         end
      end
   end
   assign out_valid = out_valid_ff;
   assign {out_dest, out_untag, out_vid, out_pcp} = out_ff[39:13];
   assign out_tag_op = evps_pkg::tag_op_t'(out_ff[12:11]);
   assign out_len = out_ff[10:0];

   // Drop counter; a drop in the clearing cycle still counts
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         drops_ff <= 16'h0;
      end else if (wr && paddr == `A_DROPS) begin
         drops_ff <= 16'(s_drop || (in_valid && !enq_ok));
      end else if (s_drop || (in_valid && !enq_ok)) begin
         drops_ff <= drops_ff + 16'h1;
      end
   end

   // Pause advertisement
   logic [3:0] adv_ff;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         adv_ff <= 4'h0;
      end else begin
         adv_ff <= ctrl_ff[`F_AN];
      end
   end
   assign adv_sym_pause = adv_ff;

   // Per-port rate bucket, pause generation and pause reception
   for (genvar p = 0; p < 4; p++) begin : g_port
      logic signed [24:0] bkt_ff, nxt_bkt;
      logic [11:0] gain;
      logic [20:0] cost;
      logic cond_ff, pause_ff, hold_ff, cond;
      logic [15:0] qcnt_ff;
      logic [7:0] presc_ff;

      assign gain = 12'(circ_ff[4*p +: 4] * `STS1_GAIN);
      assign cost = (enq_ok && in_port == 2'(p)) ? 21'(in_len) * 21'(`BYTE_COST) : 21'h0;
      always_comb begin
         nxt_bkt = bkt_ff + $signed({13'h0, gain}) - $signed({4'h0, cost});
         if (nxt_bkt > `BKT_MAX) begin
            nxt_bkt = `BKT_MAX;
         end
         if (nxt_bkt < -`BKT_MAX) begin
            nxt_bkt = -`BKT_MAX;
         end
      end
      assign cond = fc[p] && (bkt_ff[24] || congest);

      // Bucket and pause request on onset of overload
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            bkt_ff <= 25'sh0;
            cond_ff <= 1'b0;
            pause_ff <= 1'b0;
         end else begin
            bkt_ff <= nxt_bkt;
            cond_ff <= cond;
            pause_ff <= cond && !cond_ff;
         end
      end

      // Received pause time, one quantum is 512 bit times
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            qcnt_ff <= 16'h0;
            presc_ff <= 8'h0;
            hold_ff <= 1'b0;
         end else if (!fc[p]) begin
            qcnt_ff <= 16'h0;
            hold_ff <= 1'b0;
         end else if (rx_pause_valid && rx_pause_port == 2'(p)) begin
            qcnt_ff <= rx_pause_quanta;
            presc_ff <= 8'h0;
            hold_ff <= rx_pause_quanta != 16'h0;
         end else if (qcnt_ff != 16'h0) begin
            if (presc_ff == 8'(`QUANTUM_CYC - 1)) begin
               presc_ff <= 8'h0;
               qcnt_ff <= qcnt_ff - 16'h1;
               hold_ff <= qcnt_ff != 16'h1;
            end else begin
               presc_ff <= presc_ff + 8'h1;
            end
         end
      end
      assign hold_w[p] = hold_ff;
      assign pause_w[p] = pause_ff;
      assign over_w[p] = bkt_ff[24];
   end
   assign tx_hold = hold_w;
   assign tx_pause = pause_w;

   a_long_drop: assert property (@(posedge pclk) disable iff (!presetn)
      in_valid && in_len > `FRAME_MAX |-> !enq_ok)
      else $error("oversize frame queued");
   a_pm_circuit: assert property (@(posedge pclk) disable iff (!presetn)
      enq_ok && pm |-> c_dest == (8'h10 << in_port))
      else $error("mapped frame to wrong circuit");
   a_pm_plain: assert property (@(posedge pclk) disable iff (!presetn)
      enq_ok && pm |-> c_op == evps_pkg::TAG_NONE && !c_hi && c_vid == in_vid)
      else $error("mapped frame tag touched");
   a_untag_insert: assert property (@(posedge pclk) disable iff (!presetn)
      enq_ok && !pm && !in_tagged |-> c_op == evps_pkg::TAG_INSERT && c_vid == pvid)
      else $error("untagged frame lacks port tag");
   a_member_only: assert property (@(posedge pclk) disable iff (!presetn)
      enq_ok && !pm |-> (c_dest & ~ent[`E_MEM]) == 8'h00 && !c_dest[in_port])
      else $error("frame sent outside VLAN");
   a_prio_class: assert property (@(posedge pclk) disable iff (!presetn)
      enq_ok && !pm && in_tagged |-> c_hi == (in_pcp >= 3'h4))
      else $error("priority misclassified");
   a_hold_start: assert property (@(posedge pclk) disable iff (!presetn)
      rx_pause_valid && rx_pause_port == 2'h0 && fc[0] && rx_pause_quanta != 16'h0
      |=> tx_hold[0])
      else $error("pause not honoured");
   a_hold_span: assert property (@(posedge pclk) disable iff (!presetn)
      rx_pause_valid && rx_pause_port == 2'h0 && fc[0] && rx_pause_quanta == 16'h1
      ##1 (!rx_pause_valid && fc[0]) [*8] |-> tx_hold[0])
      else $error("pause quantum too short");
   a_no_fc_pause: assert property (@(posedge pclk) disable iff (!presetn)
      !fc[0] |=> !tx_pause[0])
      else $error("pause without negotiation");
   a_vlan_cap: assert property (@(posedge pclk) disable iff (!presetn) vcnt_ff <= `VLAN_MAX)
      else $error("VLAN count over limit");
   a_apb_ready: assert property (@(posedge pclk) disable iff (!presetn)
      psel && !penable |=> pready)
      else $error("no ready in access");
   c_pm_frame: cover property (@(posedge pclk) disable iff (!presetn) enq_ok && pm);
   c_hold: cover property (@(posedge pclk) disable iff (!presetn) $fell(tx_hold[0]));
   c_pause: cover property (@(posedge pclk) disable iff (!presetn) tx_pause[0]);
endmodule
`default_nettype wire

//--- bench/evps_station.sv
`timescale 1ns/1ns
`default_nettype none
module evps_station (
   input wire logic pclk, // Bus clock
   input wire logic presetn, // Async reset, active low
   input wire logic [3:0] an_en, // Stations set to auto-negotiate
   input wire logic out_valid, // Egress descriptor valid
   input wire logic [7:0] out_dest, // Egress ports
   input wire logic [3:0] out_untag, // Strip ports
   input wire logic [11:0] out_vid, // VLAN
   input wire logic [2:0] out_pcp, // Priority
   input var evps_pkg::tag_op_t out_tag_op, // Tag handling
   input wire logic [10:0] out_len, // Frame bytes
   output logic out_ready, // Egress accepts
   output logic [3:0] partner_an, // Station auto-negotiates
   output logic [31:0] got, // Descriptors taken
   output logic [47:0] last // Last descriptor taken
);
   // Stations auto-negotiate only as the bench commands
   assign partner_an = an_en;
   // Sink alternates ready, so a transfer waits at most one cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_ready <= 1'b0;
         got <= 32'h0;
         last <= 48'h0;
      end else begin
         out_ready <= ~out_ready;
         if (out_valid && out_ready) begin
            got <= got + 32'h1;
            last <= {3'h0, out_dest, out_untag, out_vid, out_pcp, 2'(out_tag_op), 5'h0, out_len};
         end
      end
   end
endmodule
`default_nettype wire

//--- bench/ethernet_vlan_port_switch_test.sv
`timescale 1ns/1ns
`default_nettype none
module ethernet_vlan_port_switch_test;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rdat, got;
   logic pready, pslverr, rerr, out_valid, out_ready;
   logic in_valid = 1'b0, in_tagged = 1'b0, rx_pause_valid = 1'b0;
   logic [1:0] in_port = 2'h0, rx_pause_port = 2'h0;
   logic [11:0] in_vid = 12'h0, out_vid;
   logic [2:0] in_pcp = 3'h0, out_pcp;
   logic [10:0] in_len = 11'h0, out_len;
   logic [15:0] rx_pause_quanta = 16'h0;
   logic [3:0] an_en = 4'hF, partner_an, out_untag, adv_sym_pause, tx_hold, tx_pause;
   logic [7:0] out_dest;
   logic [47:0] last;
   evps_pkg::tag_op_t out_tag_op;
   int miscompares = 0, num_checks = 0, cycles = 0;
   logic [3:0] paused = 4'h0;

   evps_switch evps_switch_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .in_valid(in_valid), .in_port(in_port), .in_tagged(in_tagged),
      .in_vid(in_vid), .in_pcp(in_pcp), .in_len(in_len), .partner_an(partner_an),
      .rx_pause_valid(rx_pause_valid), .rx_pause_port(rx_pause_port),
      .rx_pause_quanta(rx_pause_quanta), .out_ready(out_ready), .out_valid(out_valid),
      .out_dest(out_dest), .out_untag(out_untag), .out_vid(out_vid), .out_pcp(out_pcp),
      .out_tag_op(out_tag_op), .out_len(out_len), .adv_sym_pause(adv_sym_pause),
      .tx_hold(tx_hold), .tx_pause(tx_pause));
   evps_station evps_station_i (.pclk(pclk), .presetn(presetn), .an_en(an_en),
      .out_valid(out_valid), .out_dest(out_dest), .out_untag(out_untag), .out_vid(out_vid),
      .out_pcp(out_pcp), .out_tag_op(out_tag_op), .out_len(out_len), .out_ready(out_ready),
      .partner_an(partner_an), .got(got), .last(last));

   // 50 MHz clock and a hang limit
   always #10 pclk = ~pclk;
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      paused <= paused | tx_pause;
      if (cycles > 20000) begin
         miscompares = miscompares + 1;
         results();
      end
   end

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      num_checks = num_checks + 1;
      if (seen !== exp) begin
         miscompares = miscompares + 1;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // One APB transfer; holds the request until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Read and compare data and error flag
   task automatic rd(input string what, input logic [7:0] a, input logic [31:0] exp, input logic e);
      apb(1'b0, a, 32'h0);
      check(what, rdat, exp);
      check("slverr", {31'h0, rerr}, {31'h0, e});
   endtask

   // Offer one frame; expect it at egress or not at all
   task automatic frame(input logic [1:0] p, input logic t, input logic [11:0] v,
         input logic [2:0] q, input logic [10:0] len, input logic taken);
      logic [31:0] n0;
      int n;
      n0 = got;
      n = 0;
      @(posedge pclk);
      {in_port, in_tagged, in_vid, in_pcp, in_len} <= {p, t, v, q, len};
      in_valid <= 1'b1;
      @(posedge pclk);
      in_valid <= 1'b0;
      while (got === n0 && n < 30) begin
         @(posedge pclk);
         n = n + 1;
      end
      check("frame taken", {31'h0, got !== n0}, {31'h0, taken});
   endtask

   task automatic pause(input logic [15:0] qn);
      @(posedge pclk);
      rx_pause_port <= 2'h0;
      rx_pause_quanta <= qn;
      rx_pause_valid <= 1'b1;
      @(posedge pclk);
      rx_pause_valid <= 1'b0;
      repeat (4) @(posedge pclk);
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   initial begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      rd("ctrl", 8'h00, 32'h0000_00F0, 1'b0);
      rd("pvid", 8'h04, 32'h0001_0001, 1'b0);
      rd("unmapped", 8'h20, 32'h0, 1'b1);
      check("adv pause", {28'h0, adv_sym_pause}, 32'hF);
      apb(1'b1, 8'h00, 32'h0000_00F3);
      check("bad mode", {31'h0, rerr}, 32'h1);
      apb(1'b1, 8'h0C, 32'h0000_0004);
      check("multi cap", {31'h0, rerr}, 32'h1);
      apb(1'b1, 8'h00, 32'h0000_00F4);
      apb(1'b1, 8'h0C, 32'h0000_0006);
      rd("adddrop cap", 8'h0C, 32'h0000_0006, 1'b0);
      // Port-mapped: fixed circuit, tag untouched, size limit
      apb(1'b1, 8'h00, 32'h0000_00F2);
      frame(2'h1, 1'b1, 12'hFFF, 3'h5, 11'h5F2, 1'b1);
      check("pm desc", last[47:16], {3'h0, 8'h20, 4'h0, 12'hFFF, 3'h5, 2'h0});
      check("pm len", {16'h0, last[15:0]}, 32'h0000_05F2);
      frame(2'h1, 1'b1, 12'h064, 3'h5, 11'h5F3, 1'b0);
      rd("drops", 8'h1C, 32'h1, 1'b0);
      apb(1'b1, 8'h1C, 32'h0);
      // Single-card switch with one VLAN on all stations
      apb(1'b1, 8'h00, 32'h0000_00F1);
      apb(1'b1, 8'h0C, 32'h0000_0D00);
      check("single cap", {31'h0, rerr}, 32'h1);
      apb(1'b1, 8'h0C, 32'h0000_8888);
      check("cap wrap", {31'h0, rerr}, 32'h1);
      apb(1'b1, 8'h10, 32'h0000_0005);
      apb(1'b1, 8'h14, 32'h0010_F005);
      apb(1'b1, 8'h04, 32'h0001_0005);
      frame(2'h0, 1'b0, 12'h0, 3'h0, 11'h040, 1'b1);
      check("untag desc", last[47:16], {3'h0, 8'h0E, 4'hE, 12'h005, 3'h0, 2'h2});
      frame(2'h2, 1'b1, 12'h007, 3'h0, 11'h040, 1'b0);
      rd("drops vlan", 8'h1C, 32'h1, 1'b0);
      apb(1'b1, 8'h00, 32'h0000_0FF1);
      frame(2'h2, 1'b1, 12'h005, 3'h6, 11'h040, 1'b1);
      check("keep desc", last[47:16], {3'h0, 8'h0B, 4'h0, 12'h005, 3'h6, 2'h1});
      // Received pause holds one quantum, then only with both ends negotiating
      pause(16'h0001);
      check("hold on", {31'h0, tx_hold[0]}, 32'h1);
      repeat (260) @(posedge pclk);
      check("hold off", {31'h0, tx_hold[0]}, 32'h0);
      an_en <= 4'hE;
      pause(16'h0010);
      check("no fc hold", {31'h0, tx_hold[0]}, 32'h0);
      // Ports 1 and 2 have no circuit bandwidth, so their frames must draw a pause
      check("pause sent", {30'h0, paused[2:1]}, 32'h3);
      results();
   end
endmodule
`default_nettype wire
